//--- ppid_pkg.sv
// Constants for the port pin interrupt and drive block
// Functional notes
// RULE1 - Each implemented pin has a low/high output drive strength select bit
// RULE2 - Drive strength selection has no effect while the pin is an input
// RULE3 - Unimplemented drive strength bits ignore writes; reads return any value
// RULE4 - Read-only interrupt flag reads 1 once detected; writes ignored
// RULE5 - Writing 1 to acknowledge helps clear the flag; it always reads 0
// RULE6 - Interrupt enable bit permits the request when 1, blocks it when 0
// RULE7 - Mode bit: 0 detects edges only, 1 detects edges and levels
// RULE8 - Per-pin select bit makes that pin an interrupt source when 1
// RULE9 - Polarity bit 0 is falling/low detection, 1 is rising/high detection
// RULE10 - Polarity bit picks pull-up at 0, pull-down at 1, if pull enabled
// RULE11 - Pull-down only applies to a selected interrupt pin set for rising edges
// RULE12 - Pull devices are off for any pin configured as an output
// RULE13 - Interrupt request is asserted while flag and enable are both 1
// RULE14 - In level mode acknowledge cannot clear while a pin stays active
package ppid_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_DRIVE = 8'h00;
    localparam logic [7:0] OFS_STATCTL = 8'h04;
    localparam logic [7:0] OFS_PINSEL = 8'h08;
    localparam logic [7:0] OFS_POLSEL = 8'h0c;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
    localparam logic [7:0] OFS_EVT_MASK = 8'h14;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] DRIVE_IMPL_MASK = 8'hef;
    localparam int unsigned NUM_PINS = 8;
    localparam int unsigned NUM_IRQ_PINS = 4;
    localparam int unsigned BIT_FLAG = 3;
    localparam int unsigned BIT_ACK = 2;
    localparam int unsigned BIT_IE = 1;
    localparam int unsigned BIT_MODE = 0;
    localparam int unsigned EVT_DETECT = 0;
    localparam int unsigned EVT_REQ_RISE = 1;
    localparam int unsigned NUM_EVT = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [3:0] RST_PINSEL = 4'h0;
    localparam logic [3:0] RST_POLSEL = 4'h0;
    localparam logic [1:0] RST_EVT = 2'h0;

endpackage : ppid_pkg

//--- ppid_port.sv
// Pin interrupt detection, pull selection and drive strength for one port
`timescale 1ns/1ps

module ppid_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_is_output,
    input wire logic [7:0] pull_enable_bits,
    output logic [7:0] drive_high,
    output logic [7:0] pull_up_on,
    output logic [7:0] pull_down_on,
    output logic port_irq_req,
    output logic evt_irq
);

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [3:0] lvl_prev;
        logic [7:0] drive_strength_bits;
        logic irq_flag;
        logic irq_enable_bit;
        logic detect_mode_bit;
        logic [3:0] irq_pin_select;
        logic [3:0] irq_polarity_select;
        logic [1:0] evt_status;
        logic [1:0] evt_mask;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic [7:0] drive_high;
        logic [7:0] pull_up_on;
        logic [7:0] pull_down_on;
        logic req;
        logic evt_irq;
    } ppid_state_t;

    ppid_state_t s_q;
    ppid_state_t s_d;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [3:0] lvl;
        logic [3:0] edges;
        logic det_set;
        logic level_hold;
        logic wr;
        logic rd_phase;
        logic mapped;
        logic ack;
        logic [31:0] rd;
        logic [7:0] pull_on;
        logic [7:0] pd_sel;
        lvl = '0;
        edges = '0;
        det_set = 1'b0;
        level_hold = 1'b0;
        wr = 1'b0;
        rd_phase = 1'b0;
        mapped = 1'b0;
        ack = 1'b0;
        rd = '0;
        pull_on = '0;
        pd_sel = '0;
        s_d = s_q;

        // Pins are asynchronous: only sync2 feeds logic
        s_d.sync1 = pin_in;
        s_d.sync2 = s_q.sync1;

        // Active level per interrupt pin after polarity
        lvl = s_q.sync2[3:0] ^ ~s_q.irq_polarity_select; // RULE9
        s_d.lvl_prev = lvl;
        edges = lvl & ~s_q.lvl_prev & s_q.irq_pin_select; // RULE8
        level_hold = s_q.detect_mode_bit && ((lvl & s_q.irq_pin_select) != 4'h0); // RULE7
        det_set = (edges != 4'h0) || level_hold; // RULE7

        // Bus decode
        mapped = (paddr == ppid_pkg::OFS_DRIVE) || (paddr == ppid_pkg::OFS_STATCTL)
            || (paddr == ppid_pkg::OFS_PINSEL) || (paddr == ppid_pkg::OFS_POLSEL)
            || (paddr == ppid_pkg::OFS_EVT_STATUS) || (paddr == ppid_pkg::OFS_EVT_MASK);
        // Access completes on the edge where the registered ready is seen high
        rd_phase = psel && penable && !s_q.ready;
        wr = psel && penable && s_q.ready && pwrite && mapped;

        unique case (paddr)
            ppid_pkg::OFS_DRIVE: rd[7:0] = s_q.drive_strength_bits; // RULE3
            ppid_pkg::OFS_STATCTL: begin
                rd[ppid_pkg::BIT_FLAG] = s_q.irq_flag; // RULE4
                rd[ppid_pkg::BIT_ACK] = 1'b0; // RULE5
                rd[ppid_pkg::BIT_IE] = s_q.irq_enable_bit;
                rd[ppid_pkg::BIT_MODE] = s_q.detect_mode_bit;
            end
            ppid_pkg::OFS_PINSEL: rd[3:0] = s_q.irq_pin_select;
            ppid_pkg::OFS_POLSEL: rd[3:0] = s_q.irq_polarity_select;
            ppid_pkg::OFS_EVT_STATUS: rd[1:0] = s_q.evt_status;
            ppid_pkg::OFS_EVT_MASK: rd[1:0] = s_q.evt_mask;
            default: rd = '0;
        endcase

        s_d.ready = rd_phase;
        // Error stands only with ready, so it never lingers into an idle or setup cycle
        s_d.slverr = rd_phase && !mapped;
        if (rd_phase) begin
            s_d.rdata = (pwrite || !mapped) ? 32'h0000_0000 : rd;
        end

        // Register writes
        if (wr) begin
            unique case (paddr)
                ppid_pkg::OFS_DRIVE: begin
                    s_d.drive_strength_bits = pwdata[7:0] & ppid_pkg::DRIVE_IMPL_MASK; // RULE3 RULE1
                end
                ppid_pkg::OFS_STATCTL: begin
                    ack = pwdata[ppid_pkg::BIT_ACK]; // RULE5
                    s_d.irq_enable_bit = pwdata[ppid_pkg::BIT_IE]; // RULE6
                    s_d.detect_mode_bit = pwdata[ppid_pkg::BIT_MODE]; // RULE7
                end
                ppid_pkg::OFS_PINSEL: s_d.irq_pin_select = pwdata[3:0]; // RULE8
                ppid_pkg::OFS_POLSEL: s_d.irq_polarity_select = pwdata[3:0]; // RULE9
                ppid_pkg::OFS_EVT_STATUS: s_d.evt_status = s_q.evt_status & ~pwdata[1:0];
                ppid_pkg::OFS_EVT_MASK: s_d.evt_mask = pwdata[1:0];
                default: ;
            endcase
        end

        // Flag: set wins over acknowledge, so a held level keeps it set
        s_d.irq_flag = det_set || (s_q.irq_flag && !ack); // RULE4 RULE14
        s_d.req = s_d.irq_flag && s_d.irq_enable_bit; // RULE13 RULE6

        // Sticky events: a new event beats a same-cycle clear
        if (det_set) begin
            s_d.evt_status[ppid_pkg::EVT_DETECT] = 1'b1;
        end
        if (s_d.req && !s_q.req) begin
            s_d.evt_status[ppid_pkg::EVT_REQ_RISE] = 1'b1;
        end
        s_d.evt_irq = (s_d.evt_status & s_d.evt_mask) != 2'h0;

        // Pin controls
        s_d.drive_high = s_d.drive_strength_bits & pin_is_output; // RULE1 RULE2
        pull_on = pull_enable_bits & ~pin_is_output; // RULE12
        pd_sel[3:0] = s_d.irq_pin_select & s_d.irq_polarity_select; // RULE10 RULE11
        s_d.pull_down_on = pull_on & pd_sel; // RULE11
        s_d.pull_up_on = pull_on & ~pd_sel; // RULE10
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.drive_strength_bits <= ppid_pkg::RST_DRIVE;
            s_q.irq_pin_select <= ppid_pkg::RST_PINSEL;
            s_q.irq_polarity_select <= ppid_pkg::RST_POLSEL;
            s_q.evt_status <= ppid_pkg::RST_EVT;
            s_q.evt_mask <= ppid_pkg::RST_EVT;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.slverr;
    assign drive_high = s_q.drive_high;
    assign pull_up_on = s_q.pull_up_on;
    assign pull_down_on = s_q.pull_down_on;
    assign port_irq_req = s_q.req;
    assign evt_irq = s_q.evt_irq;

endmodule : ppid_port

//--- ppid_pin_model.sv
// External signal source driving the port pins
`timescale 1ns/1ps

module ppid_pin_model (
    input wire logic pclk,
    input wire logic [7:0] level_cmd,
    output logic [7:0] pin_in
);
    // Pins move just after a clock edge, as a slow external source would
    always_ff @(posedge pclk) begin
        pin_in <= level_cmd;
    end
endmodule : ppid_pin_model

//--- ppid_port_properties.sv
// Port-level checks of the pin interrupt and drive block
`timescale 1ns/1ps

module ppid_port_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] pin_is_output,
    input wire logic [7:0] pull_enable_bits,
    input wire logic [7:0] drive_high,
    input wire logic [7:0] pull_up_on,
    input wire logic [7:0] pull_down_on
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_data_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
        else $error("unmapped read not zero");
    ack_zero_a: assert property (
        pready && !pwrite && paddr == ppid_pkg::OFS_STATCTL |-> prdata[2] == 1'b0)
        else $error("acknowledge bit read as one");
    drive_gate_a: assert property ((drive_high & ~$past(pin_is_output)) == 8'h00)
        else $error("high drive on an input pin");
    pull_out_a: assert property (
        ((pull_up_on | pull_down_on) & $past(pin_is_output)) == 8'h00)
        else $error("pull device on an output pin");
    pull_en_a: assert property (
        ((pull_up_on | pull_down_on) & ~$past(pull_enable_bits)) == 8'h00
        && (pull_up_on & pull_down_on) == 8'h00)
        else $error("pull device without enable or both on");
    pull_down_a: assert property (pull_down_on[7:4] == 4'h0)
        else $error("pull-down on a pin without interrupt");
endmodule : ppid_port_properties

bind ppid_port ppid_port_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .pin_is_output, .pull_enable_bits, .drive_high,
    .pull_up_on, .pull_down_on);

//--- port_pin_interrupt_drive_tb.sv
// Self-checking bench for the pin interrupt and drive block
`timescale 1ns/1ps

module port_pin_interrupt_drive_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, port_irq_req, evt_irq;
    logic [7:0] paddr, pin_in, pin_is_output, pull_enable_bits, drive_high, lvl;
    logic [7:0] pull_up_on, pull_down_on;
    logic [31:0] pwdata, prdata, rd;
    logic rd_err;
    int failures = 0;
    int n_tests = 0;
    ppid_pin_model pin_u (.pclk(pclk), .level_cmd(lvl), .pin_in(pin_in));
    ppid_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_is_output(pin_is_output),
        .pull_enable_bits(pull_enable_bits), .drive_high(drive_high),
        .pull_up_on(pull_up_on), .pull_down_on(pull_down_on),
        .port_irq_req(port_irq_req), .evt_irq(evt_irq));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic test_done;
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Request stands until pready is sampled high at a rising edge; data taken there
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            test_done();
        end
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle cycle, so two calls never drive psel twice in one time step
        @(posedge pclk);
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 8'h00);
        chk(rd, e, nm);
    endtask : rchk
    task automatic s_drive;
        apb(1'b1, ppid_pkg::OFS_DRIVE, 8'hff);
        rchk(ppid_pkg::OFS_DRIVE, 32'hef, "drive");
        pin_is_output <= 8'h0f;
        repeat (3) @(posedge pclk);
        chk(drive_high, 8'h0f, "drive_high");
        apb(1'b1, 8'h20, 8'hff);
        chk({rd[7:0], rd_err}, 9'h001, "unmapped wr");
        rchk(8'h20, 32'h00, "unmapped rd");
        chk(rd_err, 1'b1, "unmapped rd err");
    endtask : s_drive
    task automatic s_edge;
        apb(1'b1, ppid_pkg::OFS_PINSEL, 8'h01);
        apb(1'b1, ppid_pkg::OFS_STATCTL, 8'h06);
        lvl <= 8'hfe;
        repeat (6) @(posedge pclk);
        rchk(ppid_pkg::OFS_STATCTL, 32'h0a, "flag");
        chk(port_irq_req, 1'b1, "irq");
        apb(1'b1, ppid_pkg::OFS_STATCTL, 8'h00);
        repeat (2) @(posedge pclk);
        chk(port_irq_req, 1'b0, "irq off");
        apb(1'b1, ppid_pkg::OFS_STATCTL, 8'h04);
        apb(1'b1, ppid_pkg::OFS_STATCTL, 8'h08);
        lvl <= 8'hfc;
        repeat (6) @(posedge pclk);
        rchk(ppid_pkg::OFS_STATCTL, 32'h00, "ack clear");
    endtask : s_edge
    task automatic s_level;
        apb(1'b1, ppid_pkg::OFS_PINSEL, 8'h04);
        apb(1'b1, ppid_pkg::OFS_POLSEL, 8'h04);
        apb(1'b1, ppid_pkg::OFS_STATCTL, 8'h05);
        repeat (6) @(posedge pclk);
        apb(1'b1, ppid_pkg::OFS_STATCTL, 8'h05);
        rchk(ppid_pkg::OFS_STATCTL, 32'h09, "level hold");
        lvl <= 8'hf8;
        repeat (6) @(posedge pclk);
        apb(1'b1, ppid_pkg::OFS_STATCTL, 8'h05);
        rchk(ppid_pkg::OFS_STATCTL, 32'h01, "level clear");
    endtask : s_level
    task automatic s_pull_evt;
        pin_is_output <= 8'h00;
        pull_enable_bits <= 8'hff;
        repeat (3) @(posedge pclk);
        chk({pull_down_on, pull_up_on}, 16'h04fb, "pulls");
        pin_is_output <= 8'h0f;
        repeat (3) @(posedge pclk);
        chk({pull_down_on, pull_up_on}, 16'h00f0, "pulls out");
        apb(1'b1, ppid_pkg::OFS_EVT_MASK, 8'h03);
        repeat (2) @(posedge pclk);
        chk(evt_irq, 1'b1, "evt_irq");
        apb(1'b1, ppid_pkg::OFS_EVT_STATUS, 8'h03);
        rchk(ppid_pkg::OFS_EVT_STATUS, 32'h00, "evt clear");
        chk(evt_irq, 1'b0, "evt_irq off");
    endtask : s_pull_evt
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; lvl = 8'hff; pin_is_output = 8'hff; pull_enable_bits = 8'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_drive();
        s_edge();
        s_level();
        s_pull_evt();
        test_done();
    end
endmodule : port_pin_interrupt_drive_tb
